/* dbsg_pkg.sv */
// Shared constants for the track-control bit stream generator
package dbsg_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int XTAL_PERIOD_NS = 1000;
  localparam int XTAL_HALF_CYCLES = XTAL_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [5:0] XTAL_HALF_LAST = 6'(XTAL_HALF_CYCLES - 1);
  localparam logic [5:0] XTAL_CNT_ZERO = 6'h00;

  // ****************************************
  // Bit counter and byte sizes
  // ****************************************
  localparam logic [3:0] BIT_COUNT_PRESET = 4'h8;
  localparam logic [3:0] BIT_COUNT_LAST = 4'hf;
  localparam logic [3:0] BIT_COUNT_STEP = 4'h1;
  localparam logic [15:0] TICK_ZERO = 16'h0000;
  localparam logic [15:0] TICK_STEP = 16'h0001;
  localparam int AUX_OUT_W = 6;

  // ****************************************
  // Readback port bit positions
  // ****************************************
  localparam int RB_UNDERFLOW = 0;
  localparam int RB_TICK_N = 1;
  localparam int RB_ZERO_WAVE = 2;
  localparam int RB_DATA_BIT = 3;
  localparam int RB_SYNC_GATE = 4;
  localparam int RB_HOLD_N = 5;
  localparam int RB_TRIGGER = 6;
  localparam int RB_DELAYED = 7;

  // ****************************************
  // Synchroniser vector layout and idle levels
  // ****************************************
  localparam int SY_SOFT_RESET = 0;
  localparam int SY_SOFT_SEL = 1;
  localparam int SY_SOFT_CLK_N = 2;
  localparam int SY_STARVE_N = 3;
  localparam int SY_ARM = 4;
  localparam int SY_OBF_N = 5;
  localparam int SY_AUXW_N = 6;
  localparam int SY_AUXR_N = 7;
  localparam int SY_BYTE_LO = 8;
  localparam int SY_HOST_LO = 16;
  localparam int SY_AUX_READ_STROBE_N_LO = 24;
  localparam int SYNC_W = 32;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 32'hff00_00ef;

endpackage

/* dbsg_sync.sv */
// Two flip-flop synchroniser for a vector of pin levels
module dbsg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

/* dbsg_generator.sv */
// Track-control bit stream generator with parallel-port host interface
// How it works
// RQ1 - Readback bit 0 reads 1 after the byte stream has underflowed.
// RQ2 - Readback bits 1..7: tick_n, zero wave, data bit, gate, hold, trigger, delayed wave.
// RQ3 - Soft reset bit high resets board logic and clears auxiliary outputs.
// RQ4 - Clock select high: each 1-to-0 soft clock write is a board edge.
// RQ5 - Clock source switches without glitch; host parks soft clock first.
// RQ6 - Reset, clock select and underflow-clear bits idle high.
// RQ7 - Crystal mode derives the master tick from 1 MHz, 1 us steps.
// RQ8 - Zero bits use a gated period counter and separate high-time mark.
// RQ9 - One bits use a third counter, 50% duty, running only on ones.
// RQ10 - Board reset forces the high mark, clearing the zero wave.
// RQ11 - Track wave is zero wave AND one wave.
// RQ12 - Zero sync gate goes low one master cycle at zero pulse start.
// RQ13 - Eight-bit shifter gives current bit, shifts on track rise, zero in.
// RQ14 - Host writes next byte at least 500 ns before current byte ends.
// RQ15 - Buffer-full is synced to tick_n as ready; the load clears it.
// RQ16 - A load presets the bit counter to 8; track rise increments it.
// RQ17 - At 15 carry sets on fall; if ready, load, preset and acknowledge.
// RQ18 - No byte ready: hold low, count stays 15, zeros out, underflow set.
// RQ19 - Underflow stays until the clear bit is driven low.
// RQ20 - Armed trigger follows the load strobe for half the last bit; the code holds it for the low phase of the last bit.
// RQ21 - External wave is the track wave delayed one master period.
// RQ22 - Six auxiliary outputs latch host data on strobe rise.
// RQ23 - Eight auxiliary inputs drive host data while read strobe is low.
// RQ24 - Data byte port is strobed, with handshake via control lines.
// RQ25 - Trigger arm polarity is a build parameter, default active high.
// RQ26 - Period and high times are host values in master clock units.
module dbsg_generator #(
  parameter bit TRIG_ARM_HIGH = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic board_soft_reset_i,
  input wire logic soft_clock_select_i,
  input wire logic soft_clock_n_i,
  input wire logic starve_clear_n_i,
  input wire logic trigger_arm_i,
  input wire logic out_buffer_full_n_i,
  input wire logic [7:0] data_byte_i,
  input wire logic [15:0] zero_period_ticks_i,
  input wire logic [15:0] zero_high_ticks_i,
  input wire logic [15:0] one_period_ticks_i,
  input wire logic aux_write_strobe_n_i,
  input wire logic aux_read_strobe_n_i,
  input wire logic [7:0] host_data_i,
  input wire logic [7:0] aux_input_i,
  output logic [7:0] signal_path_readback_o,
  output logic byte_ack_n_o,
  output logic delayed_track_wave_o,
  output logic trigger_o,
  output logic [dbsg_pkg::AUX_OUT_W-1:0] aux_output_lines_o,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [dbsg_pkg::SYNC_W-1:0] pins;
  logic [dbsg_pkg::SYNC_W-1:0] pins_s;

  assign pins = {aux_input_i, host_data_i, data_byte_i, aux_read_strobe_n_i,
    aux_write_strobe_n_i, out_buffer_full_n_i, trigger_arm_i,
    starve_clear_n_i, soft_clock_n_i, soft_clock_select_i,
    board_soft_reset_i};

  // RQ6 idle high levels
  dbsg_sync #(
    .WIDTH(dbsg_pkg::SYNC_W),
    .RESET_VALUE(dbsg_pkg::SYNC_RESET)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins),
    .sync_o(pins_s)
  );

  logic soft_reset_s;
  logic soft_sel_s;
  logic soft_level;
  logic starve_clr_n_s;
  logic arm_level;
  logic obf_n_s;
  logic auxw_n_s;
  logic auxr_n_s;
  logic [7:0] byte_s;
  logic [7:0] host_s;
  logic [7:0] aux_in_s;
  logic board_rst;

  assign soft_reset_s = pins_s[dbsg_pkg::SY_SOFT_RESET];
  assign soft_sel_s = pins_s[dbsg_pkg::SY_SOFT_SEL];
  assign soft_level = ~pins_s[dbsg_pkg::SY_SOFT_CLK_N];
  assign starve_clr_n_s = pins_s[dbsg_pkg::SY_STARVE_N];
  // RQ25 arm polarity option
  assign arm_level = TRIG_ARM_HIGH ? pins_s[dbsg_pkg::SY_ARM]
                                   : ~pins_s[dbsg_pkg::SY_ARM];
  assign obf_n_s = pins_s[dbsg_pkg::SY_OBF_N];
  assign auxw_n_s = pins_s[dbsg_pkg::SY_AUXW_N];
  assign auxr_n_s = pins_s[dbsg_pkg::SY_AUXR_N];
  assign byte_s = pins_s[dbsg_pkg::SY_BYTE_LO +: 8];
  assign host_s = pins_s[dbsg_pkg::SY_HOST_LO +: 8];
  assign aux_in_s = pins_s[dbsg_pkg::SY_AUX_READ_STROBE_N_LO +: 8];
  // RQ3 soft reset joins the system reset
  assign board_rst = rst_i | soft_reset_s;

  // ****************************************
  // Master clock generation
  // ****************************************
  logic [5:0] xtal_cnt_reg;
  logic xtal_level_reg;
  logic sel_reg;
  logic tick_level_reg;
  logic tick_prev_reg;
  logic tick;
  logic tick_fall;

  // RQ7 crystal divider, half period of the 1 MHz reference
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_cnt_reg <= dbsg_pkg::XTAL_CNT_ZERO;
      xtal_level_reg <= 1'b0;
    end else if (xtal_cnt_reg == dbsg_pkg::XTAL_HALF_LAST) begin
      xtal_cnt_reg <= dbsg_pkg::XTAL_CNT_ZERO;
      xtal_level_reg <= ~xtal_level_reg;
    end else begin
      xtal_cnt_reg <= xtal_cnt_reg + 6'h01;
    end
  end

  // RQ5 select moves only while both sources agree, so no runt edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg <= 1'b1;
    end else if (xtal_level_reg == soft_level) begin
      sel_reg <= soft_sel_s;
    end
  end

  // RQ4 soft mode: a 1-to-0 write of soft_clock_n is a rising tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_level_reg <= 1'b0;
      tick_prev_reg <= 1'b0;
    end else begin
      tick_level_reg <= sel_reg ? soft_level : xtal_level_reg;
      tick_prev_reg <= tick_level_reg;
    end
  end

  assign tick = tick_level_reg & ~tick_prev_reg;
  assign tick_fall = ~tick_level_reg & tick_prev_reg;

  // ****************************************
  // Zero and one waveform counters
  // ****************************************
  logic [7:0] shift_reg;
  logic cur_bit;
  logic [15:0] zero_cnt_reg;
  logic [15:0] one_cnt_reg;
  logic [15:0] zero_inc;
  logic [15:0] one_inc;
  logic zero_wave_reg;
  logic one_wave_reg;
  logic sync_gate_reg;
  logic zero_wrap;
  logic zero_high_mark;
  logic one_wrap;
  logic one_half_mark;

  assign cur_bit = shift_reg[7];
  assign zero_inc = zero_cnt_reg + dbsg_pkg::TICK_STEP;
  assign one_inc = one_cnt_reg + dbsg_pkg::TICK_STEP;
  // RQ26 times counted in master ticks straight from host values
  assign zero_wrap = tick & ~cur_bit & (zero_inc == zero_period_ticks_i);
  assign zero_high_mark = tick & ~cur_bit & ~zero_wrap
                        & (zero_inc == zero_high_ticks_i);
  assign one_wrap = tick & cur_bit & (one_inc == one_period_ticks_i);
  assign one_half_mark = tick & cur_bit & ~one_wrap
                       & (one_inc == (one_period_ticks_i >> 1));

  // RQ8 gated period counter; high mark ends the high phase
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      zero_cnt_reg <= dbsg_pkg::TICK_ZERO;
    end else if (zero_wrap) begin
      zero_cnt_reg <= dbsg_pkg::TICK_ZERO;
    end else if (tick & ~cur_bit) begin
      zero_cnt_reg <= zero_inc;
    end
  end

  // RQ10 reset loads zero_wave_reg low directly so the zero wave starts low
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      zero_wave_reg <= 1'b0;
    end else if (zero_wrap) begin
      zero_wave_reg <= 1'b1;
    end else if (zero_high_mark) begin
      zero_wave_reg <= 1'b0;
    end
  end

  // RQ12 gate low for one master cycle as a zero pulse starts
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      sync_gate_reg <= 1'b1;
    end else if (zero_wrap) begin
      sync_gate_reg <= 1'b0;
    end else if (tick) begin
      sync_gate_reg <= 1'b1;
    end
  end

  // RQ9 one counter runs only on ones, half high, half low
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      one_cnt_reg <= dbsg_pkg::TICK_ZERO;
      one_wave_reg <= 1'b1;
    end else if (one_wrap) begin
      one_cnt_reg <= dbsg_pkg::TICK_ZERO;
      one_wave_reg <= 1'b1;
    end else if (tick & cur_bit) begin
      one_cnt_reg <= one_inc;
      if (one_half_mark) begin
        one_wave_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Track wave and delayed copy
  // ****************************************
  logic track_reg;
  logic track_prev_reg;
  logic delayed_reg;
  logic track_rise;
  logic track_fall;

  // RQ11 track wave is the AND of both waves
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      track_reg <= 1'b0;
      track_prev_reg <= 1'b0;
    end else begin
      track_reg <= zero_wave_reg & one_wave_reg;
      track_prev_reg <= track_reg;
    end
  end

  assign track_rise = track_reg & ~track_prev_reg;
  assign track_fall = ~track_reg & track_prev_reg;

  // RQ21 one master period delay lets a scope see the first rise
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      delayed_reg <= 1'b0;
    end else if (tick) begin
      delayed_reg <= track_reg;
    end
  end

  // ****************************************
  // Byte handshake, bit counter, shifter
  // ****************************************
  logic [3:0] bit_cnt_reg;
  logic carry_reg;
  logic ready_reg;
  logic ack_n_reg;
  logic underflow_reg;
  logic load_now;
  logic hold_now;

  // RQ17 load strobe is carry while ready
  assign load_now = track_rise & carry_reg & ready_reg;
  assign hold_now = track_rise & carry_reg & ~ready_reg;

  // RQ15 ready caught on the tick_n rise, cleared by the load
  // RQ14 a byte later than half a period misses this sample
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      ready_reg <= 1'b0;
    end else if (load_now) begin
      ready_reg <= 1'b0;
    end else if (tick_fall & ack_n_reg) begin
      ready_reg <= ~obf_n_s;
    end
  end

  // RQ24 acknowledge held until the port drops buffer-full
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      ack_n_reg <= 1'b1;
    end else if (load_now) begin
      ack_n_reg <= 1'b0;
    end else if (obf_n_s) begin
      ack_n_reg <= 1'b1;
    end
  end

  // RQ17 carry rises at the track fall of the last bit
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      carry_reg <= 1'b0;
    end else if (track_rise) begin
      carry_reg <= 1'b0;
    end else if (track_fall & (bit_cnt_reg == dbsg_pkg::BIT_COUNT_LAST)) begin
      carry_reg <= 1'b1;
    end
  end

  // RQ16 preset on load, count each bit; RQ18 hold stays at 15
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      bit_cnt_reg <= dbsg_pkg::BIT_COUNT_LAST;
    end else if (load_now) begin
      bit_cnt_reg <= dbsg_pkg::BIT_COUNT_PRESET;
    end else if (track_rise & ~hold_now) begin
      bit_cnt_reg <= bit_cnt_reg + dbsg_pkg::BIT_COUNT_STEP;
    end
  end

  // RQ13 shift on track rise with zero fed in
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      shift_reg <= 8'h00;
    end else if (load_now) begin
      shift_reg <= byte_s;
    end else if (track_rise) begin
      shift_reg <= {shift_reg[6:0], 1'b0};
    end
  end

  // RQ19 sticky until cleared; a new starve wins over the clear
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      underflow_reg <= 1'b0;
    end else if (hold_now) begin
      underflow_reg <= 1'b1;
    end else if (~starve_clr_n_s) begin
      underflow_reg <= 1'b0;
    end
  end

  // ****************************************
  // Trigger and readback
  // ****************************************
  logic trigger_reg;
  logic hold_n_reg;
  logic [7:0] readback_reg;

  // RQ20 armed trigger follows the load strobe
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      trigger_reg <= 1'b0;
      hold_n_reg <= 1'b1;
    end else begin
      trigger_reg <= arm_level & carry_reg & ready_reg;
      hold_n_reg <= ~(carry_reg & ~ready_reg);
    end
  end

  // RQ1 RQ2 readback of signal path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      readback_reg <= 8'h00;
    end else begin
      readback_reg[dbsg_pkg::RB_UNDERFLOW] <= underflow_reg;
      readback_reg[dbsg_pkg::RB_TICK_N] <= ~tick_level_reg;
      readback_reg[dbsg_pkg::RB_ZERO_WAVE] <= zero_wave_reg;
      readback_reg[dbsg_pkg::RB_DATA_BIT] <= cur_bit;
      readback_reg[dbsg_pkg::RB_SYNC_GATE] <= sync_gate_reg;
      readback_reg[dbsg_pkg::RB_HOLD_N] <= hold_n_reg;
      readback_reg[dbsg_pkg::RB_TRIGGER] <= trigger_reg;
      readback_reg[dbsg_pkg::RB_DELAYED] <= delayed_reg;
    end
  end

  // ****************************************
  // Auxiliary outputs and inputs
  // ****************************************
  logic auxw_prev_reg;
  logic [dbsg_pkg::AUX_OUT_W-1:0] aux_out_reg;
  logic [7:0] host_out_reg;
  logic host_oe_reg;

  // RQ22 latch on strobe rise; RQ3 board reset clears
  always_ff @(posedge clk_i) begin
    if (board_rst) begin
      auxw_prev_reg <= 1'b1;
      aux_out_reg <= '0;
    end else begin
      auxw_prev_reg <= auxw_n_s;
      if (auxw_n_s & ~auxw_prev_reg) begin
        aux_out_reg <= host_s[dbsg_pkg::AUX_OUT_W-1:0];
      end
    end
  end

  // RQ23 inputs drive host data only while the read strobe is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_out_reg <= 8'hff;
      host_oe_reg <= 1'b0;
    end else begin
      host_out_reg <= aux_in_s;
      host_oe_reg <= ~auxr_n_s;
    end
  end

  assign signal_path_readback_o = readback_reg;
  assign byte_ack_n_o = ack_n_reg;
  assign delayed_track_wave_o = delayed_reg;
  assign trigger_o = trigger_reg;
  assign aux_output_lines_o = aux_out_reg;
  assign host_data_o = host_out_reg;
  assign host_data_oe_o = host_oe_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_starve_sticky: assert property ( // RQ19
    underflow_reg && starve_clr_n_s && !board_rst |=> underflow_reg)
    else $error("underflow dropped without clear");
  a_readback_flag: assert property ( // RQ1
    hold_now && !board_rst |=> ##1 readback_reg[dbsg_pkg::RB_UNDERFLOW])
    else $error("readback underflow bit not set");
  a_soft_reset_clr: assert property ( // RQ3
    soft_reset_s |=> aux_out_reg == '0 && !underflow_reg && !zero_wave_reg)
    else $error("soft reset did not clear board");
  a_load_preset: assert property ( // RQ16
    load_now && !board_rst |=> bit_cnt_reg == dbsg_pkg::BIT_COUNT_PRESET
      && !ack_n_reg && shift_reg == $past(byte_s))
    else $error("byte load failed");
  a_hold_count: assert property ( // RQ18
    hold_now && !board_rst |=> bit_cnt_reg == dbsg_pkg::BIT_COUNT_LAST
      && underflow_reg && !shift_reg[0])
    else $error("hold did not keep count");
  a_gate_one_tick: assert property ( // RQ12
    !sync_gate_reg && tick && !zero_wrap && !board_rst |=> sync_gate_reg)
    else $error("sync gate low too long");
  a_track_and: assert property ( // RQ11
    !board_rst && !$past(board_rst)
      |-> track_reg == $past(zero_wave_reg & one_wave_reg))
    else $error("track wave not AND of waves");
  a_clock_switch: assert property ( // RQ5
    $changed(sel_reg) |-> $past(xtal_level_reg == soft_level))
    else $error("clock select changed while sources differ");
  a_delay_period: assert property ( // RQ21
    tick && !board_rst |=> delayed_reg == $past(track_reg))
    else $error("delayed wave not one period late");
  a_xtal_half: assert property ( // RQ7
    xtal_cnt_reg == dbsg_pkg::XTAL_HALF_LAST |=> $changed(xtal_level_reg))
    else $error("crystal half period wrong");
  a_trigger_load: assert property ( // RQ20
    trigger_reg |-> $past(carry_reg && ready_reg && arm_level))
    else $error("trigger without armed load");

  c_byte_load: cover property (load_now);
  c_underflow: cover property (hold_now);
  c_trigger: cover property ($rose(trigger_reg));
  c_soft_tick: cover property (tick && sel_reg);

endmodule

/* dbsg_host_model.sv */
// Host side of the strobed data byte port
module dbsg_host_model (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [7:0] send_byte_i,
  input wire logic byte_ack_n_i,
  output logic out_buffer_full_n_o,
  output logic [7:0] data_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Port idles empty
  initial begin
    out_buffer_full_n_o = 1'b1;
    data_byte_o = 8'h00;
  end

  // one byte per handshake
  // A released bus shows inverted data so a late sample is caught
  always @(posedge clk_i) begin
    if (!out_buffer_full_n_o && !byte_ack_n_i) begin
      out_buffer_full_n_o <= 1'b1;
      data_byte_o <= ~data_byte_o;
    end else if (send_i && out_buffer_full_n_o && byte_ack_n_i) begin
      out_buffer_full_n_o <= 1'b0;
      data_byte_o <= send_byte_i;
    end
  end
endmodule

/* tb_dbsg_generator.sv */
// Self-checking bench for the bit stream generator
module tb_dbsg_generator;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals and settings
  // ****************************************
  localparam logic [15:0] ZP = 16'h000a;
  localparam logic [15:0] ZH = 16'h0003;
  localparam logic [15:0] OP = 16'h0004;
  localparam int TK = dbsg_pkg::XTAL_PERIOD_NS / dbsg_pkg::CLK_PERIOD_NS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic srst = 1'b1;
  logic sel = 1'b1;
  logic sclk_n = 1'b0;
  logic clr_n = 1'b1;
  logic arm = 1'b1;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic send = 1'b0;
  logic [7:0] sbyte = 8'h00;
  logic [7:0] drv = 8'h00;
  logic [7:0] aux_in = 8'hff;
  logic [7:0] rb, hd_o, hd_i, dbyte;
  logic ack_n, dly, trig, oe, obf_n;
  logic [5:0] aux_o;
  logic [15:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int seen = 0;
  int seed = 32'hb745d9ef;

  // Shared host data wire: the block drives it only while enabled
  assign hd_i = oe ? hd_o : drv;

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  dbsg_generator i_dbsg_generator (
    .clk_i(clk_i), .rst_i(rst_i), .board_soft_reset_i(srst),
    .soft_clock_select_i(sel), .soft_clock_n_i(sclk_n),
    .starve_clear_n_i(clr_n), .trigger_arm_i(arm),
    .out_buffer_full_n_i(obf_n), .data_byte_i(dbyte),
    .zero_period_ticks_i(ZP), .zero_high_ticks_i(ZH),
    .one_period_ticks_i(OP), .aux_write_strobe_n_i(wr_n),
    .aux_read_strobe_n_i(rd_n), .host_data_i(hd_i),
    .aux_input_i(aux_in), .signal_path_readback_o(rb),
    .byte_ack_n_o(ack_n), .delayed_track_wave_o(dly),
    .trigger_o(trig), .aux_output_lines_o(aux_o),
    .host_data_o(hd_o), .host_data_oe_o(oe));

  dbsg_host_model i_dbsg_host_model (
    .clk_i(clk_i), .send_i(send), .send_byte_i(sbyte),
    .byte_ack_n_i(ack_n), .out_buffer_full_n_o(obf_n),
    .data_byte_o(dbyte));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_pulse(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ticks(input int n);
    return 8'((n + TK / 2) / TK);
  endfunction

  task automatic end_sim();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // Waveform monitor
  // ****************************************
  // Measures the armed byte on the delayed wave, one tick per unit
  always begin
    int hi;
    int lo;
    @(posedge trig);
    hi = 0;
    while (trig === 1'b1) begin
      @(posedge clk_i);
      hi++;
    end
    // trigger spans the low phase of the last zero
    check_val(ticks(hi), 8'(ZP - ZH));
    check_val({7'h00, ack_n}, 8'h00);
    repeat (8) begin
      while (dly !== 1'b1) @(posedge clk_i);
      hi = 0;
      lo = 0;
      while (dly === 1'b1) begin
        @(posedge clk_i);
        hi++;
      end
      while (dly !== 1'b1) begin
        @(posedge clk_i);
        lo++;
      end
      if (exp_q.size() == 0) begin
        check_pulse({ticks(hi), ticks(hi + lo)}, 16'hffff);
      end else begin
        check_pulse({ticks(hi), ticks(hi + lo)}, exp_q.pop_front());
      end
      seen++;
    end
  end

  // Watchdog sized well above the longest byte sequence
  initial begin
    repeat (80000) @(posedge clk_i);
    n_fail++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int k;
    logic pt;
    step(5);
    rst_i = 1'b0;
    step(4);
    check_val(8'(aux_o), 8'h00);
    check_val({7'h00, oe}, 8'h00);
    srst = 1'b0;
    step(6);
    // soft tick level shows on the readback
    for (k = 0; k < 4; k++) begin
      sclk_n = ~sclk_n;
      step(8);
      check_val({7'h00, rb[dbsg_pkg::RB_TICK_N]}, {7'h00, sclk_n});
    end
    $display("soft clock test done");
    // park the soft clock before leaving soft mode
    sclk_n = 1'b0;
    step(8);
    sel = 1'b0;
    step(60);
    k = 0;
    pt = rb[dbsg_pkg::RB_TICK_N];
    repeat (400) begin
      step(1);
      k += (rb[dbsg_pkg::RB_TICK_N] !== pt) ? 1 : 0;
      pt = rb[dbsg_pkg::RB_TICK_N];
    end
    // crystal tick_n toggles every half microsecond
    check_val(8'(k), 8'(400 / (TK / 2)));
    $display("crystal test done");
    drv = 8'($random(seed));
    wr_n = 1'b0;
    step(4);
    wr_n = 1'b1;
    step(6);
    check_val(8'(aux_o), {2'b00, drv[5:0]});
    aux_in = 8'($random(seed));
    rd_n = 1'b0;
    step(6);
    check_val({7'h00, oe}, 8'h01);
    check_val(hd_i, aux_in);
    rd_n = 1'b1;
    step(6);
    check_val({7'h00, oe}, 8'h00);
    $display("aux test done");
    step(2000);
    for (k = 0; k < 3; k++) begin
      sbyte = 8'($random(seed));
      for (int b = 7; b >= 0; b--) begin
        exp_q.push_back(sbyte[b] ? {8'(OP / 2), 8'(OP)} : {8'(ZH), 8'(ZP)});
      end
      send = 1'b1;
      step(1);
      send = 1'b0;
      for (int g = 0; g < 20000 && seen < 8 * (k + 1); g++) step(1);
      // A byte that never shows counts as a mismatch
      check_val(8'(seen), 8'(8 * (k + 1)));
      step(800);
    end
    check_val({7'h00, rb[dbsg_pkg::RB_UNDERFLOW]}, 8'h01);
    $display("stream test done");
    sel = 1'b1;
    step(60);
    clr_n = 1'b0;
    step(10);
    clr_n = 1'b1;
    step(10);
    check_val({7'h00, rb[dbsg_pkg::RB_UNDERFLOW]}, 8'h00);
    srst = 1'b1;
    step(8);
    check_val(8'(aux_o), 8'h00);
    $display("clear and reset test done");
    end_sim();
  end
endmodule
